// File: sysctl_pkg.sv
package sysctl_pkg;
  localparam logic [7:0] ADDR_HOST_SEL = 8'h03;
  localparam logic [7:0] ADDR_SCHED_CFG = 8'h06;
  localparam logic [7:0] ADDR_SYNC_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_SYNC_STAT = 8'h09;
  localparam logic [7:0] ADDR_CRC_CNT = 8'h0A;
  localparam logic [7:0] ADDR_CRC_SETUP = 8'h0B;
  localparam logic [7:0] ADDR_SI_FMT = 8'h18;
  localparam logic [7:0] ADDR_PLL = 8'h19;
  localparam logic [7:0] ADDR_GPIO_DIR = 8'h1D;
  localparam logic [7:0] ADDR_GPIO_DRIVE = 8'h1E;
  localparam logic [7:0] ADDR_GPIO_LEVEL = 8'h1F;
  localparam logic [7:0] ADDR_PI_FMT = 8'h20;
  localparam logic [7:0] ADDR_MAP_INGRESS = 8'h21;
  localparam logic [7:0] ADDR_MAP_EGRESS = 8'h22;
  localparam logic [7:0] ADDR_POST_DATA = 8'hFE;
  localparam logic [7:0] ADDR_POST_STAT = 8'hFF;
  localparam logic [31:0] RST_SI_FMT = 32'h99999999;
  localparam logic [31:0] RST_PI_FMT = 32'h99999999;
  localparam logic [7:0] RST_HOST_SEL = 8'h00;
  localparam logic [13:0] RST_SCHED_CFG = 14'h2B12;
  localparam logic [16:0] RST_PLL = 17'h16400;
  localparam logic [31:0] SI_FMT_MASK = 32'h99999999;
  localparam logic [31:0] PI_FMT_MASK = 32'hDBDBDBDB;
  localparam int PLL_LINK_FLAG = 18;
  localparam int PLL_SYS_FLAG = 17;
  localparam int PLL_DIV_SEL = 14;
  localparam int PLL_MULT_LO = 11;
  localparam int PLL_FORCE_LOW = 8;
  localparam int PLL_HALVE = 7;
  localparam int SCHED_BURST_MODE = 4;
  localparam int MAP_WRITE_BIT = 16;
  localparam int ACCESS_OK_BIT = 2;
  localparam int REPLY_OK_BIT = 1;
  localparam int RSV0_BIT = 0;
  localparam logic [4:0] PLL_BASE_MULT = 5'h0C;
  localparam int FIFO_COUNT = 12;
  localparam int PORT_COUNT = 32;
  localparam int SI_SETTLE_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SI_SETTLE_CYCLES = (SI_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // One register access from the management interface.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

  // Link PLL settings presented to the analogue macro.
  typedef struct packed {
    logic divide_by_four;
    logic [4:0] multiplier;
    logic force_lowest;
    logic halve;
  } link_pll_type;
endpackage

// File: sysctl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  // Register access.
  input wire sysctl_pkg::reg_req_type I_REQ,
  output logic [31:0] O_RDATA,
  // Posted internal reads and overload drops.
  input wire logic I_POST_DONE,
  input wire logic [31:0] I_POST_DATA,
  input wire logic I_POST_FAIL,
  input wire logic I_DROP,
  input wire logic [15:0] I_DROP_ADDR,
  // PLL lock inputs from other domains.
  input wire logic I_LINK_PLL_LOCK,
  input wire logic I_SYS_PLL_LOCK,
  // Scheduler and CRC events.
  input wire logic [11:0] I_SYNC_LOST,
  input wire logic I_CRC_ERROR,
  // General-purpose pins.
  input wire logic [7:0] I_GPIO,
  output logic [7:0] O_GPIO,
  output logic [7:0] O_GPIO_OE,
  // Controls to the datapath, with its fail-ignore and port lookup inputs.
  output sysctl_pkg::link_pll_type O_LINK_PLL,
  output logic O_LINK_LOCK_VALID,
  output logic [31:0] O_SI_FORMAT,
  output logic O_SI_BUSY,
  output logic [31:0] O_PI_FORMAT,
  output logic O_BURST_MODE,
  output logic [3:0] O_BURST_LEN,
  output logic [1:0] O_REVISIT_MIN,
  output logic [11:0] O_SYNC_OVERRIDE,
  output logic O_CRC_BYPASS,
  output logic O_HEADER_PRESENT,
  output logic [3:0] O_HEADER_SIZE,
  output logic O_CRC_DISCARD,
  input wire logic I_FAIL_IGNORE,
  input wire logic [4:0] I_ING_PORT,
  output logic [4:0] O_ING_PORT,
  input wire logic [4:0] I_EGR_PORT,
  output logic [4:0] O_EGR_PORT
);
  import sysctl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] host_sel_r;
  logic [13:0] sched_cfg_r;
  logic [11:0] sync_clear_r;
  logic [11:0] sync_stat_r;
  logic [31:0] crc_cnt_r;
  logic [5:0] crc_setup_r;
  logic [31:0] si_fmt_r;
  logic [31:0] pi_fmt_r;
  logic [16:0] pll_r;
  logic [1:0] pll_flag_r;
  logic [7:0] gpio_dir_r;
  logic [7:0] gpio_drive_r;
  logic [16:0] map_ing_cmd_r;
  logic [16:0] map_egr_cmd_r;
  logic [31:0] post_data_r;
  logic reply_ok_r;
  logic access_ok_r;
  logic [15:0] drop_addr_r;
  logic [7:0] gpio_s1_r;
  logic [7:0] gpio_s2_r;
  logic [1:0] lock_s1_r;
  logic [1:0] lock_s2_r;
  logic [1:0] lock_prev_r;
  logic [11:0] si_wait_r;
  logic [4:0] ing_map_r [PORT_COUNT];
  logic [4:0] egr_map_r [PORT_COUNT];
  logic [1:0] lock_lost;

  assign lock_lost = lock_prev_r & ~lock_s2_r;

  // Write enable for a given address.
  function automatic logic wr_at(input logic [7:0] a);
    return I_REQ.wr && (I_REQ.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers, loaded at their defaults on reset.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      host_sel_r <= RST_HOST_SEL;
      sched_cfg_r <= RST_SCHED_CFG;
      sync_clear_r <= 12'h000;
      crc_setup_r <= 6'h00;
      si_fmt_r <= RST_SI_FMT;
      pi_fmt_r <= RST_PI_FMT;
      pll_r <= RST_PLL;
      gpio_dir_r <= 8'h00;
      gpio_drive_r <= 8'h00;
    end else begin
      if (wr_at(ADDR_HOST_SEL)) host_sel_r <= I_REQ.wdata[7:0];
      if (wr_at(ADDR_SCHED_CFG)) sched_cfg_r <= I_REQ.wdata[13:0] & 14'h3F1F;
      if (wr_at(ADDR_SYNC_CLEAR)) sync_clear_r <= I_REQ.wdata[11:0];
      if (wr_at(ADDR_CRC_SETUP)) crc_setup_r <= I_REQ.wdata[5:0];
      if (wr_at(ADDR_SI_FMT)) si_fmt_r <= I_REQ.wdata & SI_FMT_MASK;
      if (wr_at(ADDR_PI_FMT)) pi_fmt_r <= I_REQ.wdata & PI_FMT_MASK;
      if (wr_at(ADDR_PLL)) pll_r <= I_REQ.wdata[16:0] & 17'h1FF80;
      if (wr_at(ADDR_GPIO_DIR)) gpio_dir_r <= I_REQ.wdata[7:0];
      if (wr_at(ADDR_GPIO_DRIVE)) gpio_drive_r <= I_REQ.wdata[7:0];
    end
  end

  // Serial format change starts a settling window during which the host stays off.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      si_wait_r <= 12'h000;
    end else if (wr_at(ADDR_SI_FMT)) begin
      si_wait_r <= 12'(SI_SETTLE_CYCLES);
    end else if (si_wait_r != 12'h000) begin
      si_wait_r <= si_wait_r - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for lock levels and general-purpose pins.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lock_s1_r <= 2'h3;
      lock_s2_r <= 2'h3;
      lock_prev_r <= 2'h3;
      gpio_s1_r <= 8'h00;
      gpio_s2_r <= 8'h00;
    end else begin
      lock_s1_r <= {I_LINK_PLL_LOCK & ~pll_r[PLL_FORCE_LOW], I_SYS_PLL_LOCK};
      lock_s2_r <= lock_s1_r;
      lock_prev_r <= lock_s2_r;
      gpio_s1_r <= I_GPIO;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  // Unlock flags: set wins over a write-one clear.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pll_flag_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (lock_lost[i]) begin
          pll_flag_r[i] <= 1'b1;
        end else if (wr_at(ADDR_PLL) && I_REQ.wdata[PLL_SYS_FLAG + i]) begin
          pll_flag_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lost-sync flags per FIFO; a set wins over the clear bit.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_stat_r <= 12'h000;
    end else begin
      sync_stat_r <= I_SYNC_LOST | (sync_stat_r & ~sync_clear_r);
    end
  end

  // CRC error total; an error in the write cycle counts on top of the new value.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      crc_cnt_r <= 32'h00000000;
    end else if (wr_at(ADDR_CRC_CNT)) begin
      crc_cnt_r <= I_REQ.wdata + {31'h0, I_CRC_ERROR};
    end else if (I_CRC_ERROR) begin
      crc_cnt_r <= crc_cnt_r + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remap command registers and tables; the write bit self-clears.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      map_ing_cmd_r <= 17'h00000;
      map_egr_cmd_r <= 17'h00000;
    end else begin
      map_ing_cmd_r <= wr_at(ADDR_MAP_INGRESS) ? (I_REQ.wdata[16:0] & 17'h11F1F) :
        (map_ing_cmd_r & 17'h0FFFF);
      map_egr_cmd_r <= wr_at(ADDR_MAP_EGRESS) ? (I_REQ.wdata[16:0] & 17'h11F1F) :
        (map_egr_cmd_r & 17'h0FFFF);
    end
  end

  // Tables start as identity and take one pair per write command.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        ing_map_r[p] <= 5'(p);
        egr_map_r[p] <= 5'(p);
      end
    end else begin
      if (map_ing_cmd_r[MAP_WRITE_BIT]) begin
        ing_map_r[map_ing_cmd_r[12:8]] <= map_ing_cmd_r[4:0];
      end
      if (map_egr_cmd_r[MAP_WRITE_BIT]) begin
        egr_map_r[map_egr_cmd_r[12:8]] <= map_egr_cmd_r[4:0];
      end
    end
  end

  // Registered port lookups.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ING_PORT <= 5'h00;
      O_EGR_PORT <= 5'h00;
    end else begin
      O_ING_PORT <= ing_map_r[I_ING_PORT];
      O_EGR_PORT <= egr_map_r[I_EGR_PORT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Posted read result and reply status.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      post_data_r <= 32'h00000000;
      reply_ok_r <= 1'b0;
    end else if (I_POST_DONE) begin
      post_data_r <= I_POST_DATA;
      reply_ok_r <= ~I_POST_FAIL;
    end else if (I_REQ.rd && I_REQ.addr == ADDR_POST_DATA) begin
      reply_ok_r <= 1'b0;
    end
  end

  // Dropped access address and sticky access-ok; a drop wins over the read.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      access_ok_r <= 1'b0;
      drop_addr_r <= 16'h0000;
    end else if (I_DROP) begin
      access_ok_r <= 1'b0;
      drop_addr_r <= I_DROP_ADDR;
    end else if (I_REQ.rd && I_REQ.addr == ADDR_POST_STAT) begin
      access_ok_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RDATA <= 32'h00000000;
    end else if (I_REQ.rd) begin
      unique case (I_REQ.addr)
        ADDR_HOST_SEL: O_RDATA <= {24'h0, host_sel_r};
        ADDR_SCHED_CFG: O_RDATA <= {18'h0, sched_cfg_r};
        ADDR_SYNC_CLEAR: O_RDATA <= {20'h0, sync_clear_r};
        ADDR_SYNC_STAT: O_RDATA <= {20'h0, sync_stat_r};
        ADDR_CRC_CNT: O_RDATA <= crc_cnt_r;
        ADDR_CRC_SETUP: O_RDATA <= {26'h0, crc_setup_r};
        ADDR_SI_FMT: O_RDATA <= si_fmt_r;
        ADDR_PLL: O_RDATA <= {13'h0, pll_flag_r[1], pll_flag_r[0], pll_r};
        ADDR_GPIO_DIR: O_RDATA <= {24'h0, gpio_dir_r};
        ADDR_GPIO_DRIVE: O_RDATA <= {24'h0, gpio_drive_r};
        ADDR_GPIO_LEVEL: O_RDATA <= {24'h0, gpio_s2_r};
        ADDR_PI_FMT: O_RDATA <= pi_fmt_r;
        ADDR_MAP_INGRESS: O_RDATA <= {15'h0, map_ing_cmd_r};
        ADDR_MAP_EGRESS: O_RDATA <= {15'h0, map_egr_cmd_r};
        ADDR_POST_DATA: O_RDATA <= post_data_r;
        ADDR_POST_STAT: O_RDATA <= {drop_addr_r, 13'h0, access_ok_r, reply_ok_r, 1'b1};
        default: O_RDATA <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and datapath controls.
  assign O_GPIO = gpio_drive_r & gpio_dir_r;
  assign O_GPIO_OE = gpio_dir_r;
  assign O_LINK_PLL.divide_by_four = pll_r[PLL_DIV_SEL];
  // The factor runs from 12 to 19, so it needs five bits.
  assign O_LINK_PLL.multiplier = PLL_BASE_MULT + {2'b00, pll_r[PLL_MULT_LO +: 3]};
  assign O_LINK_PLL.force_lowest = pll_r[PLL_FORCE_LOW];
  assign O_LINK_PLL.halve = pll_r[PLL_HALVE];
  assign O_LINK_LOCK_VALID = lock_s2_r[1];
  assign O_SI_FORMAT = si_fmt_r;
  assign O_SI_BUSY = (si_wait_r != 12'h000);
  assign O_PI_FORMAT = pi_fmt_r;
  assign O_BURST_MODE = sched_cfg_r[SCHED_BURST_MODE];
  assign O_BURST_LEN = sched_cfg_r[3:0];
  assign O_REVISIT_MIN = sched_cfg_r[11:10];
  assign O_SYNC_OVERRIDE = sync_clear_r;
  assign O_CRC_BYPASS = crc_setup_r[5];
  assign O_HEADER_PRESENT = crc_setup_r[4];
  assign O_HEADER_SIZE = crc_setup_r[3:0];
  assign O_CRC_DISCARD = I_CRC_ERROR & ~crc_setup_r[5] & ~I_FAIL_IGNORE;
endmodule
`default_nettype wire

// File: sysctl_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs_properties
  import sysctl_pkg::*;
(
  // Clock, reset and register access.
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire sysctl_pkg::reg_req_type I_REQ,
  input wire logic [31:0] O_RDATA,
  // Pins, controls and events.
  input wire logic [7:0] O_GPIO,
  input wire logic [7:0] O_GPIO_OE,
  input wire sysctl_pkg::link_pll_type O_LINK_PLL,
  input wire logic O_LINK_LOCK_VALID,
  input wire logic O_SI_BUSY,
  input wire logic O_BURST_MODE,
  input wire logic [3:0] O_BURST_LEN,
  input wire logic [11:0] O_SYNC_OVERRIDE,
  input wire logic O_CRC_BYPASS,
  input wire logic O_CRC_DISCARD,
  input wire logic I_CRC_ERROR,
  input wire logic I_FAIL_IGNORE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  // Decoded writes of the watched registers.
  wire w_pll = I_REQ.wr && I_REQ.addr == ADDR_PLL;
  wire w_sch = I_REQ.wr && I_REQ.addr == ADDR_SCHED_CFG;

  //////////////////////////////////////////////////////////////////////////
  property p_gpio_drive; (O_GPIO & ~O_GPIO_OE) == 8'h00; endproperty
  a_gpio_drive: assert property (p_gpio_drive)
    else $error("gpio drives a pin set as input");
  property p_gpio_out; I_REQ.wr && I_REQ.addr == ADDR_GPIO_DRIVE
    |=> O_GPIO == ($past(I_REQ.wdata[7:0]) & O_GPIO_OE); endproperty
  a_gpio_out: assert property (p_gpio_out)
    else $error("output pins not taken from write");
  property p_gpio_dir; I_REQ.wr && I_REQ.addr == ADDR_GPIO_DIR
    |=> O_GPIO_OE == $past(I_REQ.wdata[7:0]); endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("pin direction not taken from write");
  property p_discard;
    O_CRC_DISCARD == (I_CRC_ERROR && !O_CRC_BYPASS && !I_FAIL_IGNORE); endproperty
  a_discard: assert property (p_discard)
    else $error("discard disagrees with error and bypass");
  property p_si_busy; I_REQ.wr && I_REQ.addr == ADDR_SI_FMT |=> O_SI_BUSY [*8]; endproperty
  a_si_busy: assert property (p_si_busy)
    else $error("serial format settle busy missing");
  // The lock level passes two synchroniser stages, so allow them to drain first.
  property p_force_low; O_LINK_PLL.force_lowest [*3] |-> !O_LINK_LOCK_VALID; endproperty
  a_force_low: assert property (p_force_low)
    else $error("lock shown while oscillator forced low");
  property p_pll_clock; w_pll |=> O_LINK_PLL.divide_by_four == $past(I_REQ.wdata[14])
    && O_LINK_PLL.multiplier == PLL_BASE_MULT + $past(I_REQ.wdata[13:11]); endproperty
  a_pll_clock: assert property (p_pll_clock)
    else $error("link clock setting not taken from write");
  property p_halve; w_pll |=> O_LINK_PLL.halve == $past(I_REQ.wdata[7]); endproperty
  a_halve: assert property (p_halve)
    else $error("halve bit not taken from write");
  property p_sched; w_sch |=> O_BURST_MODE == $past(I_REQ.wdata[4])
    && O_BURST_LEN == $past(I_REQ.wdata[3:0]); endproperty
  a_sched: assert property (p_sched)
    else $error("scheduler mode or burst length wrong");
  property p_fifo_sync_clear; I_REQ.wr && I_REQ.addr == ADDR_SYNC_CLEAR
    |=> O_SYNC_OVERRIDE == $past(I_REQ.wdata[11:0]); endproperty
  a_fifo_sync_clear: assert property (p_fifo_sync_clear)
    else $error("sync clear bits not presented");
  property p_unmapped; I_REQ.rd && I_REQ.addr == 8'h40 |=> O_RDATA == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

bind sysctl_regs sysctl_regs_properties u_props (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_REQ(I_REQ), .O_RDATA(O_RDATA), .O_GPIO(O_GPIO), .O_GPIO_OE(O_GPIO_OE),
  .O_LINK_PLL(O_LINK_PLL), .O_LINK_LOCK_VALID(O_LINK_LOCK_VALID), .O_SI_BUSY(O_SI_BUSY),
  .O_BURST_MODE(O_BURST_MODE), .O_BURST_LEN(O_BURST_LEN), .O_SYNC_OVERRIDE(O_SYNC_OVERRIDE),
  .O_CRC_BYPASS(O_CRC_BYPASS), .O_CRC_DISCARD(O_CRC_DISCARD), .I_CRC_ERROR(I_CRC_ERROR),
  .I_FAIL_IGNORE(I_FAIL_IGNORE));
`default_nettype wire

// File: sysctl_host.sv
`timescale 1ns/1ps
`default_nettype none
module sysctl_host
  import sysctl_pkg::*;
(
  // Clock and read data.
  input wire logic i_clock,
  input wire logic [31:0] i_rdata,
  // Register request.
  output sysctl_pkg::reg_req_type o_req
);
  initial o_req = '0;

  // Single write; a serial format change is followed by the settle wait.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clock);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clock);
    o_req = '0;
    if (a == ADDR_SI_FMT) repeat (SI_SETTLE_CYCLES) @(negedge i_clock);
  endtask

  // Single read; data is taken once the answer has registered.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge i_clock);
    o_req = '0;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// File: system_control_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_control_registers_tb;
  import sysctl_pkg::*;
  logic clk = 0, rst_n = 0, pdone = 0, pfail = 0, drop = 0, llock = 1, slock = 1;
  logic crc = 0, fign = 0;
  logic [31:0] pdata = '0, rdata, v;
  logic [15:0] daddr = '0;
  logic [11:0] slost = '0, sovr;
  logic [7:0] gpi = '0, gpo, goe;
  logic [4:0] ip = '0, ep = '0, op, xp;
  logic [3:0] blen, hsz;
  logic [1:0] rmin;
  logic lvalid, sbusy, bmode, byp, hdr, disc;
  logic [31:0] sfmt, pfmt;
  link_pll_type pll;
  reg_req_type req;
  int error_cnt = 0, samples_checked = 0;

  // Clock, partner host and the block.
  always #5 clk = ~clk;
  sysctl_host host (.i_clock(clk), .i_rdata(rdata), .o_req(req));
  sysctl_regs dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_REQ(req), .O_RDATA(rdata),
    .I_POST_DONE(pdone), .I_POST_DATA(pdata), .I_POST_FAIL(pfail), .I_DROP(drop),
    .I_DROP_ADDR(daddr), .I_LINK_PLL_LOCK(llock), .I_SYS_PLL_LOCK(slock),
    .I_SYNC_LOST(slost), .I_CRC_ERROR(crc), .I_GPIO(gpi), .O_GPIO(gpo), .O_GPIO_OE(goe),
    .O_LINK_PLL(pll), .O_LINK_LOCK_VALID(lvalid), .O_SI_FORMAT(sfmt), .O_SI_BUSY(sbusy),
    .O_PI_FORMAT(pfmt), .O_BURST_MODE(bmode), .O_BURST_LEN(blen), .O_REVISIT_MIN(rmin),
    .O_SYNC_OVERRIDE(sovr), .O_CRC_BYPASS(byp), .O_HEADER_PRESENT(hdr),
    .O_HEADER_SIZE(hsz), .O_CRC_DISCARD(disc), .I_FAIL_IGNORE(fign), .I_ING_PORT(ip),
    .O_ING_PORT(op), .I_EGR_PORT(ep), .O_EGR_PORT(xp));

  //////////////////////////////////////////////////////////////////////////
  // Compare, read-compare and closing.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    host.rd(a, v);
    chk(n, e, v);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Reset values of the format, scheduler, PLL, status, ingress remap and CRC count registers, then the interface formats.
  task automatic t_defaults;
    rc("si_fmt", ADDR_SI_FMT, 32'h99999999);
    rc("pi_fmt", ADDR_PI_FMT, 32'h99999999);
    rc("sched", ADDR_SCHED_CFG, 32'h00002B12);
    rc("pll", ADDR_PLL, 32'h00016400);
    rc("status", ADDR_POST_STAT, 32'h00000001);
    rc("unmapped", 8'h40, 32'h0);
    rc("remap", ADDR_MAP_INGRESS, 32'h0);
    rc("crc_cnt", ADDR_CRC_CNT, 32'h0);
    host.wr(ADDR_SI_FMT, 32'h99999999);
    chk("si_out", 32'h99999999, sfmt);
    chk("si_idle", 32'h0, {31'h0, sbusy});
    host.wr(ADDR_PI_FMT, 32'hDBDBDBDB);
    chk("pi_out", 32'hDBDBDBDB, pfmt);
    $display("test defaults done");
  endtask

  // Link PLL settings, forced-low lock and sticky unlock flags.
  task automatic t_pll;
    host.wr(ADDR_PLL, 32'h00011D80);
    repeat (3) @(negedge clk);
    chk("pll_out", 32'h3F, {24'h0, pll});
    chk("lock_low", 32'h0, {31'h0, lvalid});
    host.wr(ADDR_PLL, 32'h00016400);
    repeat (4) @(negedge clk);
    chk("lock_ok", 32'h1, {31'h0, lvalid});
    llock = 0;
    slock = 0;
    repeat (6) @(negedge clk);
    rc("pll_flags", ADDR_PLL, 32'h00076400);
    host.wr(ADDR_PLL, 32'h00076400);
    rc("pll_clr", ADDR_PLL, 32'h00016400);
    llock = 1;
    slock = 1;
    $display("test pll done");
  endtask

  // Pin direction, output drive and input sampling.
  task automatic t_gpio;
    host.wr(ADDR_GPIO_DIR, 32'hF0);
    host.wr(ADDR_GPIO_DRIVE, 32'hA5);
    chk("gpio_oe", 32'hF0, {24'h0, goe});
    chk("gpio_out", 32'hA0, {24'h0, gpo});
    gpi = 8'h3C;
    repeat (4) @(negedge clk);
    rc("gpio_in", ADDR_GPIO_LEVEL, 32'h3C);
    $display("test gpio done");
  endtask

  // Scheduler fields, lost-sync flags and their clearing.
  task automatic t_sched;
    host.wr(ADDR_SCHED_CFG, 32'h2F04);
    chk("sched_out", 32'h13, {bmode, blen, rmin});
    host.wr(ADDR_SYNC_CLEAR, 32'h801);
    chk("override", 32'h801, {20'h0, sovr});
    slost = 12'h00A;
    @(negedge clk);
    slost = '0;
    rc("lost", ADDR_SYNC_STAT, 32'h00A);
    host.wr(ADDR_SYNC_CLEAR, 32'h002);
    rc("lost_clr", ADDR_SYNC_STAT, 32'h008);
    $display("test scheduler done");
  endtask

  // CRC checker configuration, discard decision and error count.
  task automatic t_crc;
    host.wr(ADDR_CRC_SETUP, 32'h19);
    chk("crc_cfg", 32'h19, {26'h0, byp, hdr, hsz});
    for (int i = 0; i < 3; i++) begin
      if (i == 1) fign = 1;
      if (i == 2) fign = 0;
      if (i == 2) host.wr(ADDR_CRC_SETUP, 32'h39);
      @(negedge clk);
      crc = 1;
      #1 chk("discard", {31'h0, i == 0}, {31'h0, disc});
      @(negedge clk);
      crc = 0;
    end
    rc("crc_cnt", ADDR_CRC_CNT, 32'h3);
    $display("test crc done");
  endtask

  // Remap tables: one written entry in each, one untouched ingress identity entry.
  task automatic t_remap;
    host.wr(ADDR_MAP_INGRESS, 32'h10305);
    host.wr(ADDR_MAP_EGRESS, 32'h10A1F);
    repeat (2) @(negedge clk);
    ip = 5'd3;
    ep = 5'd10;
    @(negedge clk);
    chk("ing", 32'h5, {27'h0, op});
    chk("egr", 32'h1F, {27'h0, xp});
    ip = 5'd4;
    @(negedge clk);
    chk("ing_id", 32'h4, {27'h0, op});
    $display("test remap done");
  endtask

  // Posted read reply, data read, dropped access and access-ok set again by a status read.
  task automatic t_post;
    pdone = 1;
    pdata = 32'hCAFE0123;
    @(negedge clk);
    pdone = 0;
    rc("st_ok", ADDR_POST_STAT, 32'h7);
    rc("data", ADDR_POST_DATA, 32'hCAFE0123);
    rc("st_rd", ADDR_POST_STAT, 32'h5);
    drop = 1;
    daddr = 16'h1234;
    @(negedge clk);
    drop = 0;
    rc("st_drop", ADDR_POST_STAT, 32'h12340001);
    rc("st_back", ADDR_POST_STAT, 32'h12340005);
    $display("test posted done");
  endtask

  // Main sequence and watchdog.
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_defaults();
    t_pll();
    t_gpio();
    t_sched();
    t_crc();
    t_remap();
    t_post();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
